/* File: design/bci_codec.sv */
`timescale 1ns/100ps
module bci_codec
  import bci_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // octet stream
  output logic      [7:0]  tx_data_o,
  output logic      [3:0]  tx_index_o,
  output logic             tx_valid_o,
  output logic             tx_last_o,
  input  wire logic        tx_ready_i
);
  // ***************************************************
  // state and registers
  // ***************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FILL = 4'b0010,
    ST_READ = 4'b0100,
    ST_HOLD = 4'b1000
  } bci_state_t;

  bci_state_t         state;
  logic        [18:0] paging;
  logic        [9:0]  slot;
  logic        [8:0]  bcast;
  logic        [23:0] codes;
  logic        [23:0] sysinfo;
  logic        [2:0]  pattern;
  logic               msg_sel;
  logic        [3:0]  idx;
  logic        [3:0]  out_idx;
  logic signed [10:0] delay;
  logic        [7:0]  fill_byte;
  logic        [9:0]  pgroup;
  logic               cfg_err;
  logic               busy;
  logic               setup;
  logic               access;
  logic               wr_acc;
  logic               mapped;
  logic               refuse;
  logic               start;
  logic               changed;
  logic        [1:0]  cs;

  // ***************************************************
  // apb decode
  // ***************************************************
  assign busy   = (state != ST_IDLE);
  assign setup  = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= OFF_DELAY);
  assign refuse = access && (!mapped || (pwrite_i && busy && paddr_i != OFF_STATUS));
  assign wr_acc = access && pwrite_i && !refuse;
  assign start  = wr_acc && (paddr_i == OFF_CTRL) && pwdata_i[0] && !cfg_err;
  assign pready_o  = 1'b1;
  assign pslverr_o = refuse;

  always_comb begin
    changed = 1'b0;
    if (wr_acc) begin
      case (paddr_i)
        OFF_PAGING:  changed = (pwdata_i[18:0] != paging);
        OFF_SLOT:    changed = (pwdata_i[9:0] != slot);
        OFF_BCAST:   changed = (pwdata_i[8:0] != bcast);
        OFF_CODES:   changed = (pwdata_i[23:0] != codes);
        default:     changed = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      paging  <= PAGING_RST;
      slot    <= SLOT_RST;
      bcast   <= BCAST_RST;
      codes   <= CODES_RST;
      sysinfo <= SYSINFO_RST;
    end else if (wr_acc) begin
      case (paddr_i)
        OFF_PAGING:  paging  <= pwdata_i[18:0];
        OFF_SLOT:    slot    <= pwdata_i[9:0];
        OFF_BCAST:   bcast   <= pwdata_i[8:0];
        OFF_CODES:   codes   <= pwdata_i[23:0];
        OFF_SYSINFO: sysinfo <= pwdata_i[23:0];
        default:     paging  <= paging;
      endcase
    end
  end

  // pattern number advances whenever the radio message content changes
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pattern <= PATTERN_RST;
    end else if (changed) begin
      pattern <= pattern + 3'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (setup && !pwrite_i) begin
      case (paddr_i)
        OFF_CTRL:    prdata_o <= {30'h0, msg_sel, 1'b0};
        OFF_STATUS:  prdata_o <= {25'h0, pattern, 2'h0, cfg_err, busy};
        OFF_PAGING:  prdata_o <= {13'h0, paging};
        OFF_SLOT:    prdata_o <= {22'h0, slot};
        OFF_BCAST:   prdata_o <= {23'h0, bcast};
        OFF_CODES:   prdata_o <= {8'h0, codes};
        OFF_SYSINFO: prdata_o <= {8'h0, sysinfo};
        OFF_DELAY:   prdata_o <= {{21{delay[10]}}, delay};
        default:     prdata_o <= 32'h00000000;
      endcase
    end
  end

  // ***************************************************
  // configuration checks and slot delay
  // ***************************************************
  assign cs = paging[PG_CS +: 2];
  // paging group number: slots x division factor x same-group count
  assign pgroup = {7'h0, paging[PG_PC +: 3]} * {6'h0, paging[PG_GDF +: 4]} *
                  {7'h0, ((paging[PG_SG +: 3] == 3'h0) ? 3'h1 : paging[PG_SG +: 3])};
  assign cfg_err = (cs == CS_RESERVED) ||
                   (bcast[BC_IDL +: 5] > IDL_MAX) ||
                   ((cs == CS_INDEP || cs == CS_RELATED) && pgroup > PGROUP_MAX);

  // delay in units of 0.625 ms
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      delay <= 11'sh000;
    end else begin
      delay <= $signed({2'b00, slot[SL_OFF +: 6], SLOT_EIGHTHS'(0)} + {9'h0, slot[SL_OTH +: 2]}
               - {9'h0, slot[SL_LOC +: 2]});
    end
  end

  // ***************************************************
  // octet builder
  // ***************************************************
  always_comb begin
    fill_byte = 8'h00;
    if (!msg_sel) begin
      case (idx)
        4'h4: fill_byte = {(cs == CS_RELATED) && paging[PG_OE], 1'b0,
                           paging[PG_SG +: 3], paging[PG_SV +: 3]};
        4'h5: fill_byte = {cs, paging[PG_PC +: 3], paging[PG_FBU +: 3]};
        4'h6: fill_byte = (cs == CS_INDEP || cs == CS_RELATED) ?
                          {slot[SL_OTH +: 2], slot[SL_OFF +: 6]} : 8'h00;
        4'h7: fill_byte = {2'b00, bcast[BC_OPT], bcast[BC_SYS], pattern, 1'b0};
        4'h8: fill_byte = {6'h00, bcast[BC_V2], bcast[BC_V1]};
        4'h9: fill_byte = {3'h0, bcast[BC_IDL +: 5]};
        4'hA: fill_byte = codes[CD_CC + 4 +: 8];
        4'hB: fill_byte = {codes[CD_CC +: 4], codes[CD_NC + 8 +: 4]};
        4'hC: fill_byte = codes[CD_NC +: 8];
        default: fill_byte = 8'h00;
      endcase
    end else begin
      case (idx)
        4'h1: fill_byte = {SYS_MSG_TYPE, 4'h0};
        4'h2: fill_byte = {7'h00, sysinfo[SI_RST]};
        4'h3: fill_byte = sysinfo[SI_CLS +: 8];
        4'h4: fill_byte = sysinfo[SI_CLS + 8 +: 8];
        4'hB: fill_byte = {5'h00, sysinfo[SI_STA +: 3]};
        4'hC: fill_byte = {sysinfo[SI_RCV +: 4], 4'h0};
        default: fill_byte = 8'h00;
      endcase
    end
  end

  // ***************************************************
  // sequencer
  // ***************************************************
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (start) begin
          state <= ST_FILL;
        end
        ST_FILL: if (idx == OCTET_LAST) begin
          state <= ST_READ;
        end
        ST_READ: state <= ST_HOLD;
        ST_HOLD: if (tx_ready_i) begin
          state <= (out_idx == OCTET_LAST) ? ST_IDLE : ST_READ;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      msg_sel <= 1'b0;
    end else if (start) begin
      msg_sel <= pwdata_i[1];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      idx <= RADIO_FIRST;
    end else if (start) begin
      idx <= pwdata_i[1] ? SYS_FIRST : RADIO_FIRST;
    end else if (state == ST_FILL) begin
      idx <= (idx == OCTET_LAST) ? (msg_sel ? SYS_FIRST : RADIO_FIRST) : idx + 4'h1;
    end else if (state == ST_READ) begin
      idx <= idx + 4'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      out_idx <= 4'h0;
    end else if (state == ST_READ) begin
      out_idx <= idx;
    end
  end

  bci_msg_mem u_mem (
    .clock_i   (clock_i),
    .wr_en_i   (state == ST_FILL),
    .wr_addr_i (idx),
    .wr_data_i (fill_byte),
    .rd_en_i   (state == ST_READ),
    .rd_addr_i (idx),
    .rd_data_o (tx_data_o)
  );

  assign tx_index_o = out_idx;
  assign tx_valid_o = (state == ST_HOLD);
  assign tx_last_o  = (state == ST_HOLD) && (out_idx == OCTET_LAST);

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  bad_cfg_refused_a: assert property (
    (wr_acc && paddr_i == OFF_CTRL && pwdata_i[0] && cfg_err && !busy) |=> state == ST_IDLE)
    else $error("start taken with invalid configuration");
  carrier_code_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'h5) |-> tx_data_o[7:6] != CS_RESERVED)
    else $error("reserved carrier structure sent");
  single_no_offset_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'h6 && cs == 2'h0) |-> tx_data_o == 8'h00)
    else $error("other slot fields sent for single channel");
  slot_delay_a: assert property (
    (wr_acc && paddr_i == OFF_SLOT) |=> ##1
      delay == $signed({2'b00, $past(pwdata_i[7:2], 2), 3'h0}) + $signed({9'h0, $past(pwdata_i[1:0], 2)})
               - $signed({9'h0, $past(pwdata_i[9:8], 2)}))
    else $error("slot delay wrong");
  pattern_step_a: assert property (
    changed |=> pattern == $past(pattern) + 3'h1)
    else $error("pattern did not advance");
  octet7_layout_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'h7) |->
      tx_data_o[7:6] == 2'h0 && !tx_data_o[0] && tx_data_o[3:1] == pattern)
    else $error("octet 7 layout wrong");
  version_bits_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'h8) |-> tx_data_o[7:2] == 6'h00)
    else $error("reserved version bits set");
  id_length_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'h9) |-> tx_data_o[7:5] == 3'h0 && tx_data_o[4:0] <= IDL_MAX)
    else $error("station id length invalid");
  sys_type_a: assert property (
    (tx_valid_o && msg_sel && out_idx == SYS_FIRST) |-> tx_data_o == {SYS_MSG_TYPE, 4'h0})
    else $error("sysinfo type octet wrong");
  odd_even_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'h4 && cs != CS_RELATED) |-> !tx_data_o[7])
    else $error("odd/even flag set outside related mode");
  stream_hold_a: assert property (
    (tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_data_o) && $stable(out_idx))
    else $error("octet dropped before accepted");
  battery_save_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'h4) |-> !tx_data_o[6] && tx_data_o[2:0] == paging[PG_SV +: 3])
    else $error("battery save field wrong");
  paging_count_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'h5) |-> tx_data_o[5:3] == paging[PG_PC +: 3])
    else $error("paging slot count wrong");
  unit_length_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'h5) |-> tx_data_o[2:0] == paging[PG_FBU +: 3])
    else $error("frame basic unit length wrong");
  other_slot_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'h6 && cs != 2'h0) |-> tx_data_o[7:6] == slot[SL_OTH +: 2])
    else $error("other slot position wrong");
  frame_offset_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'h6 && cs != 2'h0) |-> tx_data_o[5:0] == slot[SL_OFF +: 6])
    else $error("other slot frame offset wrong");
  bcast_flags_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'h7) |-> tx_data_o[4] == bcast[BC_SYS] && tx_data_o[5] == bcast[BC_OPT])
    else $error("broadcast presence flags wrong");
  country_code_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'hA) |-> tx_data_o == codes[CD_CC + 4 +: 8])
    else $error("country code octet wrong");
  network_code_a: assert property (
    (tx_valid_o && !msg_sel && out_idx == 4'hC) |-> tx_data_o == codes[CD_NC +: 8])
    else $error("network code octet wrong");
  restrict_flag_a: assert property (
    (tx_valid_o && msg_sel && out_idx == 4'h2) |-> tx_data_o == {7'h00, sysinfo[SI_RST]})
    else $error("restriction flag octet wrong");
  restrict_class_a: assert property (
    (tx_valid_o && msg_sel && out_idx == 4'h3) |-> tx_data_o == sysinfo[SI_CLS +: 8])
    else $error("restriction class octet wrong");
  sys_status_a: assert property (
    (tx_valid_o && msg_sel && out_idx == 4'hB) |-> tx_data_o == {5'h00, sysinfo[SI_STA +: 3]})
    else $error("status number octet wrong");
  reception_ind_a: assert property (
    (tx_valid_o && msg_sel && out_idx == 4'hC) |-> tx_data_o == {sysinfo[SI_RCV +: 4], 4'h0})
    else $error("reception indication octet wrong");
endmodule : bci_codec

/* File: design/bci_pkg.sv */
package bci_pkg;
  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_PAGING  = 8'h08;
  localparam logic [7:0] OFF_SLOT    = 8'h0C;
  localparam logic [7:0] OFF_BCAST   = 8'h10;
  localparam logic [7:0] OFF_CODES   = 8'h14;
  localparam logic [7:0] OFF_SYSINFO = 8'h18;
  localparam logic [7:0] OFF_DELAY   = 8'h1C;
  // ***************************************************
  // field positions
  // ***************************************************
  localparam int PG_SV  = 0;   // battery save repeat, 3 bits
  localparam int PG_PC  = 3;   // paging slot count, 3 bits
  localparam int PG_FBU = 6;   // frame basic unit length, 3 bits
  localparam int PG_CS  = 9;   // control carrier structure, 2 bits
  localparam int PG_OE  = 11;  // odd/even group flag
  localparam int PG_GDF = 12;  // group division factor, 4 bits
  localparam int PG_SG  = 16;  // same paging group count, 3 bits
  localparam int SL_OTH = 0;   // other absolute slot code, 2 bits
  localparam int SL_OFF = 2;   // other slot frame offset, 6 bits
  localparam int SL_LOC = 8;   // local absolute slot code, 2 bits
  localparam int BC_SYS = 0;
  localparam int BC_OPT = 1;
  localparam int BC_V1  = 2;
  localparam int BC_V2  = 3;
  localparam int BC_IDL = 4;   // station id area length code, 5 bits
  localparam int CD_CC  = 0;   // country code, 12 bits
  localparam int CD_NC  = 12;  // network code, 12 bits
  localparam int SI_RST = 0;   // restriction flag
  localparam int SI_CLS = 1;   // restriction class, 16 bits
  localparam int SI_STA = 17;  // sysinfo status number, 3 bits
  localparam int SI_RCV = 20;  // reception indication, 4 bits
  // ***************************************************
  // widths, reset values, codes
  // ***************************************************
  localparam logic [18:0] PAGING_RST  = 19'h00000;
  localparam logic [9:0]  SLOT_RST    = 10'h000;
  localparam logic [8:0]  BCAST_RST   = 9'h000;
  localparam logic [23:0] CODES_RST   = 24'h000000;
  localparam logic [23:0] SYSINFO_RST = 24'h000000;
  localparam logic [2:0]  PATTERN_RST = 3'h0;
  localparam logic [1:0]  CS_RESERVED = 2'h3;
  localparam logic [1:0]  CS_RELATED  = 2'h2;
  localparam logic [1:0]  CS_INDEP    = 2'h1;
  localparam logic [4:0]  IDL_MAX     = 5'h19;
  localparam logic [9:0]  PGROUP_MAX  = 10'h07F;
  localparam logic [3:0]  SYS_MSG_TYPE = 4'h2;
  localparam logic [3:0]  RADIO_FIRST = 4'h4;
  localparam logic [3:0]  SYS_FIRST   = 4'h1;
  localparam logic [3:0]  OCTET_LAST  = 4'hC;
  localparam logic [2:0]  SLOT_EIGHTHS = 3'h3;  // 5 ms = 8 x 0.625 ms
endpackage : bci_pkg

/* File: design/bci_msg_mem.sv */
`timescale 1ns/100ps
module bci_msg_mem (
  // clock
  input  wire logic       clock_i,
  // write port
  input  wire logic       wr_en_i,
  input  wire logic [3:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i,
  // read port
  input  wire logic       rd_en_i,
  input  wire logic [3:0] rd_addr_i,
  output logic      [7:0] rd_data_o
);
  logic [7:0] mem [0:15];

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule : bci_msg_mem

/* File: tb/bci_sink.sv */
`timescale 1ns/100ps
module bci_sink (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  // octet stream
  input  wire logic [7:0] tx_data_i,
  input  wire logic [3:0] tx_index_i,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_last_i,
  output logic            tx_ready_o,
  // pacing
  input  wire logic [3:0] stall_i
);
  // ********************
  // receiving station
  // ********************
  logic [7:0] octet [1:12];
  logic [3:0] cnt;
  logic [3:0] prev_index;
  logic       reserved_seen;
  int         frames;
  int         seq_errs;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tx_ready_o    <= 1'b0;
      cnt           <= 4'h0;
      prev_index    <= 4'h0;
      reserved_seen <= 1'b0;
      frames        <= 0;
      seq_errs      <= 0;
    end else if (tx_valid_i && tx_ready_o) begin
      octet[tx_index_i] <= tx_data_i;
      tx_ready_o        <= 1'b0;
      cnt               <= 4'h0;
      prev_index        <= tx_last_i ? 4'h0 : tx_index_i;
      if (tx_last_i) begin
        frames <= frames + 1;
      end
      if ((prev_index != 4'h0 && tx_index_i != prev_index + 4'h1) || (tx_last_i && tx_index_i != 4'hC)) begin
        seq_errs <= seq_errs + 1;
      end
      if (tx_index_i == 4'h5 && tx_data_i[7:6] == 2'h3) begin
        reserved_seen <= 1'b1;
      end
    end else if (tx_valid_i) begin
      cnt        <= cnt + 4'h1;
      tx_ready_o <= (cnt >= stall_i);
    end
  end
endmodule : bci_sink

/* File: tb/bci_codec_bench.sv */
`timescale 1ns/100ps
module bci_codec_bench import bci_pkg::*;;
  // ********************
  // signals
  // ********************
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rq;
  logic        pready, pslverr, re, tx_valid, tx_last, tx_ready;
  logic [7:0]  tx_data;
  logic [3:0]  tx_index, stall = 4'h0;
  logic [7:0]  want [1:12];
  int          err_total = 0, total_checks = 0;

  always #2 clock_i = ~clock_i;

  bci_codec u_bci_codec (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .tx_data_o(tx_data), .tx_index_o(tx_index), .tx_valid_o(tx_valid), .tx_last_o(tx_last),
    .tx_ready_i(tx_ready)
  );
  bci_sink u_bci_sink (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .tx_data_i(tx_data), .tx_index_i(tx_index),
    .tx_valid_i(tx_valid), .tx_last_i(tx_last), .tx_ready_o(tx_ready), .stall_i(stall)
  );

  // ********************
  // helpers
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] expv);
    total_checks++;
    if (got !== expv) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, expv);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic frame(input logic [31:0] ctl, input int first);
    int f0;
    int n;
    f0 = u_bci_sink.frames;
    n = 0;
    apb(1'b1, OFF_CTRL, ctl);
    chk({31'h0, re}, 32'h0);
    apb(1'b1, OFF_CTRL, ctl);
    chk({31'h0, re}, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({31'h0, rq[0]}, 32'h1);
    while (u_bci_sink.frames == f0 && n < 400) begin
      @(posedge clock_i);
      n++;
    end
    chk({31'h0, n < 400}, 32'h1);
    for (int i = first; i <= 12; i++) chk({24'h0, u_bci_sink.octet[i]}, {24'h0, want[i]});
    chk(u_bci_sink.seq_errs, 32'h0);
  endtask : frame

  task automatic cfg_case(input logic [1:0] cs, input logic [2:0] pc, input logic [3:0] gdf,
                          input logic [2:0] sg, input logic e);
    apb(1'b1, OFF_PAGING, {13'h0, sg, gdf, 1'b0, cs, 3'h0, pc, 3'h0});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({31'h0, rq[1]}, {31'h0, e});
  endtask : cfg_case

  // ********************
  // scenarios
  // ********************
  task automatic t_reset;
    for (int a = 0; a < 32; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(rq, 32'h0);
      chk({31'h0, re}, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, re}, 32'h1);
    apb(1'b1, 8'h0A, 32'h7);
    chk({31'h0, re}, 32'h1);
    apb(1'b0, OFF_PAGING, 32'h0);
    chk(rq, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_radio;
    apb(1'b1, OFF_PAGING, 32'h00012DDF);
    apb(1'b1, OFF_SLOT, 32'h000001AA);
    apb(1'b1, OFF_BCAST, 32'h00000195);
    apb(1'b1, OFF_CODES, 32'h0000A1B8);
    apb(1'b1, OFF_PAGING, 32'h00012DDF);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rq, 32'h40);
    apb(1'b0, OFF_DELAY, 32'h0);
    chk({21'h0, rq[10:0]}, 32'h151);
    stall <= 4'h3;
    want = '{8'h00, 8'h00, 8'h00, 8'h8F, 8'h9F, 8'hAA, 8'h18, 8'h01, 8'h19, 8'h1B, 8'h80, 8'h0A};
    frame(32'h1, 4);
    apb(1'b1, OFF_PAGING, 32'h000129DF);
    stall <= 4'h1;
    want = '{8'h00, 8'h00, 8'h00, 8'h0F, 8'h1F, 8'h00, 8'h1A, 8'h01, 8'h19, 8'h1B, 8'h80, 8'h0A};
    frame(32'h1, 4);
    apb(1'b1, OFF_SLOT, 32'h00000300);
    apb(1'b0, OFF_DELAY, 32'h0);
    chk({21'h0, rq[10:0]}, 32'h7FD);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rq, 32'h60);
    chk({31'h0, u_bci_sink.reserved_seen}, 32'h0);
    $display("test radio done");
  endtask : t_radio

  task automatic t_sysinfo;
    apb(1'b1, OFF_SYSINFO, 32'h002B4B87);
    stall <= 4'h0;
    want = '{8'h20, 8'h01, 8'hC3, 8'hA5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h20};
    frame(32'h3, 1);
    $display("test sysinfo done");
  endtask : t_sysinfo

  task automatic t_cfg;
    cfg_case(2'h3, 3'h1, 4'h1, 3'h1, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({31'h0, rq[0]}, 32'h0);
    cfg_case(2'h1, 3'h4, 4'h8, 3'h4, 1'b1);
    cfg_case(2'h2, 3'h4, 4'h8, 3'h4, 1'b1);
    cfg_case(2'h0, 3'h4, 4'h8, 3'h4, 1'b0);
    cfg_case(2'h1, 3'h7, 4'h9, 3'h0, 1'b0);
    cfg_case(2'h1, 3'h7, 4'h6, 3'h3, 1'b0);
    apb(1'b1, OFF_BCAST, 32'h000001A0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({31'h0, rq[1]}, 32'h1);
    apb(1'b1, OFF_BCAST, 32'h00000190);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({31'h0, rq[1]}, 32'h0);
    $display("test config done");
  endtask : t_cfg

  task automatic t_indep;
    apb(1'b1, OFF_PAGING, 32'h00036A7A);
    apb(1'b1, OFF_SLOT, 32'h000000FF);
    apb(1'b1, OFF_BCAST, 32'h00000192);
    apb(1'b0, OFF_DELAY, 32'h0);
    chk({21'h0, rq[10:0]}, 32'h1FB);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rq, 32'h10);
    stall <= 4'h2;
    want = '{8'h00, 8'h00, 8'h00, 8'h1A, 8'h79, 8'hFF, 8'h22, 8'h00, 8'h19, 8'h1B, 8'h80, 8'h0A};
    frame(32'h1, 4);
    $display("test independent done");
  endtask : t_indep

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  initial begin
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_radio();
    t_sysinfo();
    t_cfg();
    t_indep();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    close_out();
  end
endmodule : bci_codec_bench
